// file: hdl/tspt_top.sv
// TCP stream pattern tester: AXI4-Lite registers, pattern generator and checker.
// Assumes an offload engine FIFO pair and one clock for bus and data.
//
// Behaviour
// - Writing the command register with bit 0 clear starts the generator.
// - While enabled, the transmit write enable is the inverse of the FIFO full flag.
// - A transmit word counter totals the words already written.
// - Transmit data is an incrementing pattern of 32-bit words made from the counter.
// - The generator stops after writing the word whose counter equals the configured size minus one.
// - The checker drains with or without comparison as the verify flag says.
// - With verification on, a mismatch of a valid word sets the failure flag unless a user reset falls in the same cycle.
// - The receive read enable is the inverse of the receive FIFO empty flag.
// - The read enable delayed one clock is the receive counter's count enable.
// - The expected pattern comes from the receive counter, aligned with the data.
// - Writing bit 0 of the reset register resets generator and checker.
// - Bit 16 of the reset register reads the Ethernet link-up status.
// - Bit 0 of the reset register reads the generator busy state.
// - The failure flag clears on a new start or on the user reset.
// - The received length counts bus words and clears on any command write.
`timescale 1ns/100ps
`default_nettype none
`include "tspt_map.svh"
module tspt_top #(
  parameter int DATA_W = 512
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_up,
  input wire logic tx_fifo_full,
  output logic tx_fifo_write_enable,
  output logic [DATA_W-1:0] tx_fifo_write_data,
  input wire logic rx_fifo_empty,
  input wire logic [DATA_W-1:0] rx_fifo_read_data,
  output logic rx_fifo_read_enable,
  output logic irq
);
  import tspt_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  typedef struct packed {
    tspt_addr_t aw;
    logic aw_full;
    tspt_wdata_t w;
    logic w_full;
    logic bvalid;
    logic [1:0] bresp;
    tspt_rd_state_t rd_state;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] configured_tx_size;
    logic verify_enable;
    logic gen_start;
    logic chk_start;
    logic soft_rst;
    logic [`TSPT_INT_W-1:0] int_sts;
    logic [`TSPT_INT_W-1:0] int_msk;
  } tspt_top_st_t;

  tspt_top_st_t st_ff;
  tspt_top_st_t nxt_st;
  logic gen_busy;
  logic gen_done;
  logic [31:0] rx_len;
  logic fail_flag;
  logic fail_evt;
  logic do_write;
  logic [11:0] wa;
  logic [`TSPT_INT_W-1:0] evt;

  assign do_write = st_ff.aw_full & st_ff.w_full & ~st_ff.bvalid;
  assign wa = st_ff.aw.addr;
  assign evt = {fail_evt, gen_done};

  // ----------------------------------------------------------------
  // Bus and register logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.gen_start = 1'b0;
    nxt_st.chk_start = 1'b0;
    nxt_st.soft_rst = 1'b0;
    if (s_axi_awvalid && !st_ff.aw_full) begin
      nxt_st.aw.addr = s_axi_awaddr;
      nxt_st.aw_full = 1'b1;
    end
    if (s_axi_wvalid && !st_ff.w_full) begin
      nxt_st.w.data = s_axi_wdata;
      nxt_st.w.strb = s_axi_wstrb;
      nxt_st.w_full = 1'b1;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // Hardware events are merged after the software clear so a same-cycle event survives.
    if (do_write) begin
      nxt_st.aw_full = 1'b0;
      nxt_st.w_full = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `TSPT_RESP_OKAY;
      case (wa)
        `TSPT_OFF_CMD: begin
          nxt_st.chk_start = 1'b1;
          nxt_st.verify_enable = st_ff.w.data[`TSPT_CMD_VERIFY_BIT];
          if (!st_ff.w.data[`TSPT_CMD_RX_BIT]) begin
            nxt_st.gen_start = 1'b1;
          end
        end
        `TSPT_OFF_TXLEN: begin
          for (int b = 0; b < 4; b++) begin
            if (st_ff.w.strb[b]) begin
              nxt_st.configured_tx_size[b*8 +: 8] = st_ff.w.data[b*8 +: 8];
            end
          end
        end
        `TSPT_OFF_RST: begin
          nxt_st.soft_rst = st_ff.w.data[`TSPT_RST_SOFT_BIT];
        end
        `TSPT_OFF_INTSTS: begin
          nxt_st.int_sts = st_ff.int_sts & ~st_ff.w.data[`TSPT_INT_W-1:0];
        end
        `TSPT_OFF_INTMSK: begin
          nxt_st.int_msk = st_ff.w.data[`TSPT_INT_W-1:0];
        end
        `TSPT_OFF_RXLEN: begin
          nxt_st.bresp = `TSPT_RESP_OKAY;
        end
        default: begin
          nxt_st.bresp = `TSPT_RESP_SLVERR;
        end
      endcase
    end
    nxt_st.int_sts = nxt_st.int_sts | evt;
    case (st_ff.rd_state)
      TSPT_RD_IDLE: begin
        if (s_axi_arvalid) begin
          nxt_st.rd_state = TSPT_RD_RESP;
          nxt_st.rresp = `TSPT_RESP_OKAY;
          nxt_st.rdata = 32'h00000000;
          case (s_axi_araddr)
            `TSPT_OFF_CMD: begin
              nxt_st.rdata[`TSPT_CMD_VERIFY_BIT] = st_ff.verify_enable;
            end
            `TSPT_OFF_TXLEN: begin
              nxt_st.rdata = st_ff.configured_tx_size;
            end
            `TSPT_OFF_RST: begin
              nxt_st.rdata[`TSPT_RST_BUSY_BIT] = gen_busy;
              nxt_st.rdata[`TSPT_RST_FAIL_BIT] = fail_flag;
              nxt_st.rdata[`TSPT_RST_LINK_BIT] = link_up;
            end
            `TSPT_OFF_RXLEN: begin
              nxt_st.rdata = rx_len;
            end
            `TSPT_OFF_INTSTS: begin
              nxt_st.rdata[`TSPT_INT_W-1:0] = st_ff.int_sts;
            end
            `TSPT_OFF_INTMSK: begin
              nxt_st.rdata[`TSPT_INT_W-1:0] = st_ff.int_msk;
            end
            default: begin
              nxt_st.rresp = `TSPT_RESP_SLVERR;
            end
          endcase
        end
      end
      TSPT_RD_RESP: begin
        if (s_axi_rready) begin
          nxt_st.rd_state = TSPT_RD_IDLE;
        end
      end
      default: begin
        nxt_st.rd_state = TSPT_RD_IDLE;
      end
    endcase
    if (!aresetn) begin
      nxt_st = '0;
      nxt_st.rd_state = TSPT_RD_IDLE;
      nxt_st.configured_tx_size = `TSPT_TXLEN_RST;
      nxt_st.int_msk = `TSPT_MSK_RST;
      nxt_st.soft_rst = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  assign s_axi_awready = ~st_ff.aw_full;
  assign s_axi_wready = ~st_ff.w_full;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = (st_ff.rd_state == TSPT_RD_IDLE);
  assign s_axi_rvalid = (st_ff.rd_state == TSPT_RD_RESP);
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign irq = |(st_ff.int_sts & st_ff.int_msk);

  // ----------------------------------------------------------------
  // Pattern engines
  // ----------------------------------------------------------------
  tspt_pattern_generator #(
    .DATA_W(DATA_W)
  ) u_gen (
    .aclk(aclk),
    .soft_rst(st_ff.soft_rst),
    .start(st_ff.gen_start),
    .configured_tx_size(st_ff.configured_tx_size),
    .tx_fifo_full(tx_fifo_full),
    .tx_fifo_write_enable(tx_fifo_write_enable),
    .tx_fifo_write_data(tx_fifo_write_data),
    .busy(gen_busy),
    .done_pulse(gen_done)
  );

  tspt_pattern_checker #(
    .DATA_W(DATA_W)
  ) u_chk (
    .aclk(aclk),
    .soft_rst(st_ff.soft_rst),
    .start(st_ff.chk_start),
    .verify_enable(st_ff.verify_enable),
    .rx_fifo_empty(rx_fifo_empty),
    .rx_fifo_read_data(rx_fifo_read_data),
    .rx_fifo_read_enable(rx_fifo_read_enable),
    .rx_word_counter(rx_len),
    .verify_fail_flag(fail_flag),
    .fail_pulse(fail_evt)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_start_sets_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff.gen_start && !st_ff.soft_rst) |=> gen_busy)
    else $error("generator not busy after start");
  a_reset_clears_all: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff.soft_rst |=> (!gen_busy && !fail_flag && rx_len == 32'h00000000))
    else $error("user reset left state behind");
  a_cmd_clears_len: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff.chk_start |=> (rx_len == 32'h00000000 && (!fail_flag || fail_evt)))
    else $error("command write did not clear length and failure");
  a_busy_read_back: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `TSPT_OFF_RST)
      |=> (s_axi_rdata[`TSPT_RST_BUSY_BIT] == $past(gen_busy)
        && s_axi_rdata[`TSPT_RST_LINK_BIT] == $past(link_up)))
    else $error("reset register read back wrong");
  a_idle_no_write: assert property (@(posedge aclk) disable iff (!aresetn)
    !gen_busy |-> !tx_fifo_write_enable)
    else $error("write enable while generator idle");
  a_len_counts_word: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_fifo_read_enable && !st_ff.chk_start && !st_ff.soft_rst)
      ##1 (!st_ff.chk_start && !st_ff.soft_rst)
      |=> rx_len == $past(rx_len) + 32'h00000001)
    else $error("received length did not follow delayed read");
endmodule // tspt_top
`default_nettype wire

// file: hdl/tspt_map.svh
// Register offsets, field positions and reset values of the stream pattern tester.
// Assumes inclusion by bare name from files under hdl/.
`ifndef TSPT_MAP_SVH
`define TSPT_MAP_SVH

`define TSPT_OFF_CMD 12'h000
`define TSPT_OFF_RST 12'h008
`define TSPT_OFF_TXLEN 12'h004
`define TSPT_OFF_RXLEN 12'h010
`define TSPT_OFF_INTSTS 12'h020
`define TSPT_OFF_INTMSK 12'h024

`define TSPT_CMD_RX_BIT 0
`define TSPT_CMD_VERIFY_BIT 1
`define TSPT_RST_SOFT_BIT 0
`define TSPT_RST_BUSY_BIT 0
`define TSPT_RST_FAIL_BIT 1
`define TSPT_RST_LINK_BIT 16

`define TSPT_INT_TXDONE_BIT 0
`define TSPT_INT_FAIL_BIT 1
`define TSPT_INT_W 2

`define TSPT_TXLEN_RST 32'h00000000
`define TSPT_MSK_RST 2'h0
`define TSPT_RESP_OKAY 2'h0
`define TSPT_RESP_SLVERR 2'h2

`endif

// file: hdl/tspt_pkg.sv
// Types shared by the stream pattern tester modules.
// Assumes nothing beyond a SystemVerilog compiler.
package tspt_pkg;
  typedef struct packed {
    logic [11:0] addr;
  } tspt_addr_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } tspt_wdata_t;

  typedef enum logic [1:0] {
    TSPT_RD_IDLE = 2'b00,
    TSPT_RD_RESP = 2'b01
  } tspt_rd_state_t;
endpackage

// file: hdl/tspt_pattern_generator.sv
// Transmit pattern generator that fills the offload engine's transmit FIFO.
// Assumes the FIFO takes a word on every clock with write enable high.
`timescale 1ns/100ps
`default_nettype none
module tspt_pattern_generator #(
  parameter int DATA_W = 512
) (
  input wire logic aclk,
  input wire logic soft_rst,
  input wire logic start,
  input wire logic [31:0] configured_tx_size,
  input wire logic tx_fifo_full,
  output logic tx_fifo_write_enable,
  output logic [DATA_W-1:0] tx_fifo_write_data,
  output logic busy,
  output logic done_pulse
);
  import tspt_pkg::*;

  typedef struct packed {
    logic tx_transfer_enable;
    logic [31:0] tx_word_counter;
    logic done;
  } tspt_gen_st_t;

  tspt_gen_st_t st_ff;
  tspt_gen_st_t nxt_st;
  logic wr;

  assign wr = st_ff.tx_transfer_enable & ~tx_fifo_full;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (soft_rst) begin
      nxt_st.tx_transfer_enable = 1'b0;
      nxt_st.tx_word_counter = 32'h00000000;
    end else if (start) begin
      nxt_st.tx_transfer_enable = 1'b1;
      nxt_st.tx_word_counter = 32'h00000000;
    end else if (wr) begin
      nxt_st.tx_word_counter = st_ff.tx_word_counter + 32'h00000001;
      if (st_ff.tx_word_counter == configured_tx_size - 32'h00000001) begin
        nxt_st.tx_transfer_enable = 1'b0;
        nxt_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  // Each 32-bit lane carries the counter-based word so the pattern rises by one lane per lane.
  always_comb begin
    tx_fifo_write_data = '0;
    for (int i = 0; i < DATA_W / 32; i++) begin
      tx_fifo_write_data[i*32 +: 32] = {st_ff.tx_word_counter[27:0], 4'h0} + 32'(i);
    end
  end

  assign tx_fifo_write_enable = wr;
  assign busy = st_ff.tx_transfer_enable;
  assign done_pulse = st_ff.done;

  a_gen_stops_full: assert property (@(posedge aclk) tx_fifo_full |-> !tx_fifo_write_enable)
    else $error("write enable high while transmit FIFO full");
  a_gen_count_step: assert property (@(posedge aclk) disable iff (soft_rst)
    (tx_fifo_write_enable && !start) |=> (st_ff.tx_word_counter == $past(st_ff.tx_word_counter) + 32'h00000001
      || soft_rst))
    else $error("transmit counter did not advance on a write");
endmodule // tspt_pattern_generator
`default_nettype wire

// file: hdl/tspt_pattern_checker.sv
// Receive pattern checker that drains the offload engine's receive FIFO.
// Assumes read data appears one clock after the read enable.
`timescale 1ns/100ps
`default_nettype none
module tspt_pattern_checker #(
  parameter int DATA_W = 512
) (
  input wire logic aclk,
  input wire logic soft_rst,
  input wire logic start,
  input wire logic verify_enable,
  input wire logic rx_fifo_empty,
  input wire logic [DATA_W-1:0] rx_fifo_read_data,
  output logic rx_fifo_read_enable,
  output logic [31:0] rx_word_counter,
  output logic verify_fail_flag,
  output logic fail_pulse
);
  import tspt_pkg::*;

  typedef struct packed {
    logic rx_read_enable_delayed;
    logic [31:0] rx_word_counter;
    logic fail;
    logic fail_evt;
  } tspt_chk_st_t;

  tspt_chk_st_t st_ff;
  tspt_chk_st_t nxt_st;
  logic [DATA_W-1:0] expected_pattern;
  logic mismatch;

  assign rx_fifo_read_enable = ~rx_fifo_empty;

  // The expected word is built from the counter that lags the read by one clock.
  always_comb begin
    expected_pattern = '0;
    for (int i = 0; i < DATA_W / 32; i++) begin
      expected_pattern[i*32 +: 32] = {st_ff.rx_word_counter[27:0], 4'h0} + 32'(i);
    end
  end

  assign mismatch = st_ff.rx_read_enable_delayed & verify_enable &
    (rx_fifo_read_data != expected_pattern);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.fail_evt = 1'b0;
    nxt_st.rx_read_enable_delayed = rx_fifo_read_enable;
    if (st_ff.rx_read_enable_delayed) begin
      nxt_st.rx_word_counter = st_ff.rx_word_counter + 32'h00000001;
    end
    if (soft_rst || start) begin
      nxt_st.rx_word_counter = 32'h00000000;
      nxt_st.fail = 1'b0;
      nxt_st.rx_read_enable_delayed = 1'b0;
    end
    // A mismatch on the cycle of a new start still sets the flag; only a user reset in the same cycle drops it.
    if (mismatch && !soft_rst) begin
      nxt_st.fail = 1'b1;
      nxt_st.fail_evt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  assign rx_word_counter = st_ff.rx_word_counter;
  assign verify_fail_flag = st_ff.fail;
  assign fail_pulse = st_ff.fail_evt;

  a_chk_fail_sticky: assert property (@(posedge aclk) disable iff (soft_rst)
    (verify_fail_flag && !start) |=> verify_fail_flag)
    else $error("failure flag dropped without clear");
  a_chk_read_empty: assert property (@(posedge aclk) rx_fifo_read_enable == !rx_fifo_empty)
    else $error("read enable not inverse of empty");
  a_chk_no_verify: assert property (@(posedge aclk) disable iff (soft_rst)
    (!verify_enable && !verify_fail_flag && !start) |=> !verify_fail_flag)
    else $error("failure raised with verification off");
endmodule // tspt_pattern_checker
`default_nettype wire

// file: test/tspt_fifo_partner.sv
// Behavioural model of the offload engine's transmit and receive FIFO ports.
// Assumes one clock shared with the tester and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module tspt_fifo_partner #(
  parameter int DATA_W = 64
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stall_tx,
  input wire logic load_rx,
  input wire logic rx_keep,
  input wire logic [31:0] load_cnt,
  input wire logic [31:0] bad_idx,
  output logic tx_fifo_full,
  input wire logic tx_fifo_write_enable,
  input wire logic [DATA_W-1:0] tx_fifo_write_data,
  output logic rx_fifo_empty,
  output logic [DATA_W-1:0] rx_fifo_read_data,
  input wire logic rx_fifo_read_enable,
  output logic [31:0] tx_words,
  output logic [31:0] tx_bad
);
  logic [1:0] phase;
  logic [31:0] rx_left;
  logic [31:0] rx_idx;

  // ----------------------------------------
  // Word pattern, one 32-bit value per lane.
  // ----------------------------------------
  function automatic logic [DATA_W-1:0] pat(input logic [31:0] k);
    for (int i = 0; i < DATA_W / 32; i++) begin
      pat[i*32 +: 32] = {k[27:0], 4'h0} + i;
    end
  endfunction

  assign tx_fifo_full = stall_tx & phase[1];
  assign rx_fifo_empty = !aresetn || (rx_left == 32'h00000000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 2'h0;
      tx_words <= 32'h00000000;
      tx_bad <= 32'h00000000;
      rx_left <= 32'h00000000;
      rx_idx <= 32'h00000000;
      rx_fifo_read_data <= '0;
    end else begin
      phase <= phase + 2'h1;
      if (tx_fifo_write_enable && tx_fifo_full) begin
        tx_bad <= tx_bad + 32'h1;
      end else if (tx_fifo_write_enable) begin
        if (tx_fifo_write_data !== pat(tx_words)) begin
          tx_bad <= tx_bad + 32'h1;
        end
        tx_words <= tx_words + 32'h1;
      end
      if (load_rx) begin
        rx_left <= load_cnt;
        // A kept index lets a follow-on burst continue the stream the checker expects.
        if (!rx_keep) begin
          rx_idx <= 32'h00000000;
        end
      end else if (rx_fifo_read_enable && !rx_fifo_empty) begin
        // A corrupted word is only sent where the bench names its index.
        rx_fifo_read_data <= (rx_idx == bad_idx) ? ~pat(rx_idx) : pat(rx_idx);
        rx_idx <= rx_idx + 32'h1;
        rx_left <= rx_left - 32'h1;
      end else begin
        // Stale data is scrambled so a late sample never matches by luck.
        rx_fifo_read_data <= ~rx_fifo_read_data;
      end
    end
  end
endmodule // tspt_fifo_partner
`default_nettype wire

// file: test/tspt_top_bench.sv
// Self-checking bench for the stream pattern tester with a FIFO partner model.
// Assumes the register map header and a 250 MHz single clock.
`timescale 1ns/100ps
`default_nettype none
`include "tspt_map.svh"
module tspt_top_bench;
  localparam int DW = 64;
  logic aclk, aresetn, link_up, stall_tx, load_rx, rx_keep;
  logic [31:0] load_cnt, bad_idx, tx_words, tx_bad;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic tx_full, tx_we, rx_empty, rx_re, irq;
  logic [DW-1:0] tx_data, rx_data;
  int error_cnt, compares, cycles;

  tspt_top #(.DATA_W(DW)) u_tspt_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_up(link_up), .tx_fifo_full(tx_full), .tx_fifo_write_enable(tx_we), .tx_fifo_write_data(tx_data),
    .rx_fifo_empty(rx_empty), .rx_fifo_read_data(rx_data), .rx_fifo_read_enable(rx_re), .irq(irq));

  tspt_fifo_partner #(.DATA_W(DW)) u_tspt_fifo_partner (.aclk(aclk), .aresetn(aresetn),
    .stall_tx(stall_tx), .load_rx(load_rx), .rx_keep(rx_keep), .load_cnt(load_cnt), .bad_idx(bad_idx),
    .tx_fifo_full(tx_full), .tx_fifo_write_enable(tx_we), .tx_fifo_write_data(tx_data),
    .rx_fifo_empty(rx_empty), .rx_fifo_read_data(rx_data), .rx_fifo_read_enable(rx_re),
    .tx_words(tx_words), .tx_bad(tx_bad));

  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string msg);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(d & m, e, msg);
  endtask

  // Polls a field until it matches or 300 reads pass; it reports no failure itself.
  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      axi_read(a, d, r);
      n++;
    end while (((d & m) !== e) && n < 300);
  endtask

  task automatic load(input logic [31:0] cnt, input logic [31:0] bad);
    load_rx <= 1'b1;
    load_cnt <= cnt;
    bad_idx <= bad;
    @(posedge aclk);
    load_rx <= 1'b0;
    @(posedge aclk);
    check({31'h0, rx_re}, 32'h00000001, "read enable");
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic test_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(`TSPT_OFF_TXLEN, 32'hFFFFFFFF, `TSPT_TXLEN_RST, "txlen reset");
    rd_chk(`TSPT_OFF_RST, 32'h00010003, 32'h00010000, "link up");
    link_up <= 1'b0;
    rd_chk(`TSPT_OFF_RST, 32'h00010000, 32'h00000000, "link down");
    axi_read(12'h0FC, d, r);
    check({d[29:0], r}, {30'h0, `TSPT_RESP_SLVERR}, "unmapped read");
    axi_write(12'h0FC, 32'h1, r);
    check({30'h0, r}, {30'h0, `TSPT_RESP_SLVERR}, "unmapped write");
  endtask

  task automatic test_tx();
    stall_tx <= 1'b1;
    wr(`TSPT_OFF_TXLEN, 32'd24);
    rd_chk(`TSPT_OFF_TXLEN, 32'hFFFFFFFF, 32'd24, "txlen");
    wr(`TSPT_OFF_RST, 32'h1);
    wr(`TSPT_OFF_CMD, 32'h0);
    rd_chk(`TSPT_OFF_RST, 32'h1, 32'h1, "busy");
    poll(`TSPT_OFF_RST, 32'h1, 32'h0);
    rd_chk(`TSPT_OFF_RST, 32'h1, 32'h0, "idle");
    check(tx_words, 32'd24, "tx words");
    check(tx_bad, 32'd0, "tx pattern or full");
    rd_chk(`TSPT_OFF_INTSTS, 32'h3, 32'h1, "done status");
    check({31'h0, irq}, 32'h0, "irq masked");
    wr(`TSPT_OFF_INTMSK, 32'h1);
    check({31'h0, irq}, 32'h1, "irq raised");
    wr(`TSPT_OFF_INTSTS, 32'h1);
    check({31'h0, irq}, 32'h0, "irq cleared");
    stall_tx <= 1'b0;
  endtask

  task automatic test_rx();
    wr(`TSPT_OFF_CMD, 32'h3);
    load(32'd10, 32'hFFFFFFFF);
    poll(`TSPT_OFF_RXLEN, 32'hFFFFFFFF, 32'd10);
    rd_chk(`TSPT_OFF_RXLEN, 32'hFFFFFFFF, 32'd10, "rx length");
    rd_chk(`TSPT_OFF_RST, 32'h2, 32'h0, "good data");
    wr(`TSPT_OFF_CMD, 32'h3);
    load(32'd8, 32'd5);
    poll(`TSPT_OFF_RXLEN, 32'hFFFFFFFF, 32'd8);
    rd_chk(`TSPT_OFF_RST, 32'h2, 32'h2, "bad word");
    rd_chk(`TSPT_OFF_INTSTS, 32'h2, 32'h2, "fail status");
    rx_keep <= 1'b1;
    load(32'd4, 32'hFFFFFFFF);
    poll(`TSPT_OFF_RXLEN, 32'hFFFFFFFF, 32'd12);
    rx_keep <= 1'b0;
    rd_chk(`TSPT_OFF_RST, 32'h2, 32'h2, "fail held");
    wr(`TSPT_OFF_RST, 32'h1);
    rd_chk(`TSPT_OFF_RST, 32'h2, 32'h0, "fail reset");
    wr(`TSPT_OFF_CMD, 32'h3);
    load(32'd3, 32'd1);
    poll(`TSPT_OFF_RXLEN, 32'hFFFFFFFF, 32'd3);
    rd_chk(`TSPT_OFF_RST, 32'h2, 32'h2, "fail again");
    wr(`TSPT_OFF_CMD, 32'h3);
    rd_chk(`TSPT_OFF_RST, 32'h2, 32'h0, "fail new start");
    rd_chk(`TSPT_OFF_RXLEN, 32'hFFFFFFFF, 32'd0, "rx length clear");
    wr(`TSPT_OFF_CMD, 32'h1);
    load(32'd6, 32'd2);
    poll(`TSPT_OFF_RXLEN, 32'hFFFFFFFF, 32'd6);
    rd_chk(`TSPT_OFF_RST, 32'h2, 32'h0, "no verify");
    wr(`TSPT_OFF_INTSTS, 32'h3);
    rd_chk(`TSPT_OFF_INTSTS, 32'h3, 32'h0, "status cleared");
  endtask

  // ----------------------------------------
  // Clock, reset, sequence and verdict.
  // ----------------------------------------
  task automatic summarize();
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // The ceiling leaves ample room over the few hundred cycles the tests need.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    error_cnt = 0;
    compares = 0;
    cycles = 0;
    aresetn = 1'b0;
    link_up = 1'b1;
    stall_tx = 1'b0;
    load_rx = 1'b0;
    rx_keep = 1'b0;
    load_cnt = 32'h0;
    bad_idx = 32'hFFFFFFFF;
    awaddr = 12'h000;
    araddr = 12'h000;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    test_regs();
    test_tx();
    test_rx();
    summarize();
  end
endmodule // tspt_top_bench
`default_nettype wire
